// ==== hw/pcrs_pkg.sv ====
// pcrs_pkg: constants, register map and carrier types for the program
// counter and return stack block.
// assumes: nothing; files that use it refer to it by pcrs_pkg::name.
package pcrs_pkg;

  localparam int PcW     = 21;
  localparam int SpW     = 5;
  localparam int Depth   = 31;
  localparam int AddrW   = 3;

  // register indices on the plain register port
  localparam logic [2:0] RegPcLow  = 3'h0;
  localparam logic [2:0] RegLatHi  = 3'h1;
  localparam logic [2:0] RegLatUp  = 3'h2;
  localparam logic [2:0] RegTosLow = 3'h3;
  localparam logic [2:0] RegTosHi  = 3'h4;
  localparam logic [2:0] RegTosUp  = 3'h5;
  localparam logic [2:0] RegStkPtr = 3'h6;

  // pointer register field positions
  localparam int BitFull  = 7;
  localparam int BitUnder = 6;

  localparam logic [4:0]    SpEmpty  = 5'h00;
  localparam logic [4:0]    SpTop    = 5'h1f;
  localparam logic [4:0]    SpOne    = 5'h01;
  localparam logic [20:0]   PcReset  = 21'h000000;
  localparam logic [20:0]   PcStep   = 21'h000002;
  localparam logic [2:0]    UpperPad = 3'h0;

  typedef struct packed {
    logic        advance;   // sequential fetch
    logic        branch;    // absolute goto/relative branch target load, no push
    logic        push;      // call, relative_call_op or interrupt acknowledge
    logic        pushInsn;  // explicit push instruction
    logic        pop;       // return, return_with_literal_op, return_from_interrupt_op
    logic        popInsn;   // explicit pop instruction
    logic [20:0] target;
  } pcrs_ctl_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pcrs_bus_t;

  typedef enum logic [2:0] {
    StIdle  = 3'b001,
    StRun   = 3'b010,
    StFault = 3'b100
  } pcrs_state_t;

endpackage

// ==== hw/pcrs_stack_mem.sv ====
// pcrs_stack_mem: return stack storage, registered read port.
// assumes: caller never addresses index zero with a write.
`timescale 1ns/1ns
module pcrs_stack_mem #(
  parameter int Depth = 31,
  parameter int Width = 21,
  parameter int AW    = 5
) (
  input  wire logic             ref_clk,
  input  wire logic             clkEn,
  input  wire logic             wrEn,
  input  wire logic [AW-1:0]    wrAddr,
  input  wire logic [Width-1:0] wrData,
  input  wire logic [AW-1:0]    rdAddr,
  output logic      [Width-1:0] rdData
);

  // entry zero exists only in the index space, it has no storage
  logic [Width-1:0] mem [1:Depth];

  always_ff @(posedge ref_clk) begin
    if (clkEn && wrEn && wrAddr != '0) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clkEn) begin
      rdData <= (rdAddr == '0) ? '0 : mem[rdAddr];
    end
  end

endmodule

// ==== hw/pcrs_flag.sv ====
// pcrs_flag: sticky status bit, hardware set wins over software clear.
// assumes: porClear is a synchronous power-on clear pulse.
`timescale 1ns/1ns
module pcrs_flag (
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic clkEn,
  input  wire logic setEv,
  input  wire logic swClear,
  input  wire logic porClear,
  output logic      flag_q
);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      flag_q <= 1'b0;
    end else if (clkEn) begin
      if (setEv) begin
        flag_q <= 1'b1;
      end else if (swClear || porClear) begin
        flag_q <= 1'b0;
      end
    end
  end

endmodule

// ==== hw/pcrs_core.sv ====
// pcrs_core: program counter with latched upper bytes and 31-level
// return address stack with pointer, top-of-stack access and flags.
// assumes: execution logic on ref_clk issues at most one of push, pop,
// branch, advance per cycle; software uses the plain register port.
`timescale 1ns/1ns
module pcrs_core #(
  parameter int Depth = pcrs_pkg::Depth
) (
  input  wire logic                ref_clk,
  input  wire logic                resetn,
  input  wire logic                clkEn,
  input  wire logic                porClear,
  input  wire logic                faultResetEn,
  input  wire pcrs_pkg::pcrs_ctl_t ctl,
  input  wire pcrs_pkg::pcrs_bus_t bus,
  output logic [7:0]               rdData,
  output logic [20:0]              pcOut,
  output logic                     stackFull,
  output logic                     stackUnder,
  output logic                     deviceResetReq
);

  ////////////////////////////////////////////////////////////////////////
  // state

  logic [20:0] pc_q;
  logic [20:0] pc_d;
  logic [7:0]  latHi_q;
  logic [4:0]  latUp_q;
  logic [4:0]  sp_q;
  logic [4:0]  sp_d;
  logic [20:0] stack_top_entry;
  logic [20:0] tosRaw;
  logic        fwdHit_q;
  logic [20:0] fwdData_q;
  logic        memWr;
  logic [4:0]  memWrAddr;
  logic [20:0] memWrData;
  logic [7:0]  rdData_q;
  logic        resetReq_q;
  pcrs_pkg::pcrs_state_t state_q;

  logic busWr;
  logic busRd;
  logic anyPush;
  logic anyPop;
  logic atTop;
  logic isEmpty;
  logic fullEv;
  logic underEv;
  logic faultEv;
  logic swClrFull;
  logic swClrUnder;
  logic tosWr;

  assign busWr   = bus.wr;
  assign busRd   = bus.rd;
  assign anyPush = ctl.push || ctl.pushInsn;
  assign anyPop  = ctl.pop || ctl.popInsn;
  assign atTop   = (sp_q == pcrs_pkg::SpTop);
  assign isEmpty = (sp_q == pcrs_pkg::SpEmpty);

  assign fullEv  = anyPush && (sp_q == pcrs_pkg::SpTop - pcrs_pkg::SpOne);
  assign underEv = anyPop && isEmpty;
  assign faultEv = fullEv && faultResetEn;

  ////////////////////////////////////////////////////////////////////////
  // stack storage and flags

  pcrs_stack_mem #(
    .Depth (Depth),
    .Width (pcrs_pkg::PcW),
    .AW    (pcrs_pkg::SpW)
  ) uMem (
    .ref_clk (ref_clk),
    .clkEn   (clkEn),
    .wrEn    (memWr),
    .wrAddr  (memWrAddr),
    .wrData  (memWrData),
    .rdAddr  (sp_d),
    .rdData  (tosRaw)
  );

  ////////////////////////////////////////////////////////////////////////
  // top-of-stack bypass

  // storage reads before it writes: an entry written on the edge that
  // the pointer lands on it would come out stale for one cycle, which
  // a back to back push and return would restore into the pc
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fwdHit_q  <= 1'b0;
      fwdData_q <= pcrs_pkg::PcReset;
    end else if (clkEn) begin
      fwdHit_q  <= memWr && (memWrAddr == sp_d);
      fwdData_q <= memWrData;
    end
  end

  assign stack_top_entry = fwdHit_q ? fwdData_q : tosRaw;

  // software clears by writing zero into a flag bit; ones are ignored
  assign swClrFull  = busWr && bus.addr == pcrs_pkg::RegStkPtr
                      && !bus.wdata[pcrs_pkg::BitFull];
  assign swClrUnder = busWr && bus.addr == pcrs_pkg::RegStkPtr
                      && !bus.wdata[pcrs_pkg::BitUnder];

  pcrs_flag uFull (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .clkEn    (clkEn),
    .setEv    (fullEv),
    .swClear  (swClrFull),
    .porClear (porClear),
    .flag_q   (stackFull)
  );

  pcrs_flag uUnder (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .clkEn    (clkEn),
    .setEv    (underEv),
    .swClear  (swClrUnder),
    .porClear (porClear),
    .flag_q   (stackUnder)
  );

  ////////////////////////////////////////////////////////////////////////
  // stack pointer and storage write

  assign tosWr = busWr && (bus.addr == pcrs_pkg::RegTosLow
                 || bus.addr == pcrs_pkg::RegTosHi
                 || bus.addr == pcrs_pkg::RegTosUp);

  always_comb begin
    sp_d      = sp_q;
    memWr     = 1'b0;
    memWrAddr = sp_q;
    memWrData = pc_q;
    if (faultEv) begin
      // store pc plus two, then pointer goes to zero
      memWr     = 1'b1;
      memWrAddr = pcrs_pkg::SpTop;
      memWrData = pc_q + pcrs_pkg::PcStep;
      sp_d      = pcrs_pkg::SpEmpty;
    end else if (anyPush) begin
      // no overwrite and no move once at 31
      if (!atTop) begin
        // pc already names the next instruction
        sp_d      = sp_q + pcrs_pkg::SpOne;
        memWr     = 1'b1;
        memWrAddr = sp_q + pcrs_pkg::SpOne;
      end
    end else if (anyPop) begin
      // pc taken first, pointer drops after
      if (!isEmpty) begin
        sp_d = sp_q - pcrs_pkg::SpOne;
      end
    end else if (busWr && bus.addr == pcrs_pkg::RegStkPtr) begin
      sp_d = bus.wdata[4:0];
    end else if (tosWr && !isEmpty) begin
      // software edits stack top, one byte at a time
      memWr = 1'b1;
      memWrData = stack_top_entry;
      if (bus.addr == pcrs_pkg::RegTosLow) begin
        memWrData[7:0] = bus.wdata;
      end else if (bus.addr == pcrs_pkg::RegTosHi) begin
        memWrData[15:8] = bus.wdata;
      end else begin
        memWrData[20:16] = bus.wdata[4:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sp_q <= pcrs_pkg::SpEmpty;
    end else if (clkEn) begin
      sp_q <= sp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // program counter

  always_comb begin
    pc_d = pc_q;
    if (faultEv) begin
      pc_d = pcrs_pkg::PcReset;
    end else if (anyPush && ctl.push) begin
      // calls also branch to their target in the same step
      pc_d = ctl.target;
    end else if (ctl.pop) begin
      pc_d = isEmpty ? pcrs_pkg::PcReset : stack_top_entry;
    end else if (ctl.branch) begin
      pc_d = ctl.target;
    end else if (busWr && bus.addr == pcrs_pkg::RegPcLow) begin
      // latches move in with low byte
      pc_d = {latUp_q, latHi_q, bus.wdata};
    end else if (ctl.advance) begin
      pc_d = pc_q + pcrs_pkg::PcStep;
    end
    pc_d[0] = 1'b0;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pc_q <= pcrs_pkg::PcReset;
    end else if (clkEn) begin
      pc_q <= pc_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // latches; call and return paths never touch them

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      latHi_q <= 8'h00;
      latUp_q <= 5'h00;
    end else if (clkEn) begin
      if (busRd && bus.addr == pcrs_pkg::RegPcLow) begin
        latHi_q <= pc_q[15:8];
        latUp_q <= pc_q[20:16];
      end else if (busWr && bus.addr == pcrs_pkg::RegLatHi) begin
        latHi_q <= bus.wdata;
      end else if (busWr && bus.addr == pcrs_pkg::RegLatUp) begin
        latUp_q <= bus.wdata[4:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port, data one cycle after strobe

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdData_q <= 8'h00;
    end else if (clkEn) begin
      rdData_q <= 8'h00;
      if (busRd) begin
        if (bus.addr == pcrs_pkg::RegPcLow) begin
          rdData_q <= pc_q[7:0];
        end else if (bus.addr == pcrs_pkg::RegLatHi) begin
          rdData_q <= latHi_q;
        end else if (bus.addr == pcrs_pkg::RegLatUp) begin
          rdData_q <= {pcrs_pkg::UpperPad, latUp_q};
        end else if (bus.addr == pcrs_pkg::RegTosLow) begin
          rdData_q <= stack_top_entry[7:0];
        end else if (bus.addr == pcrs_pkg::RegTosHi) begin
          rdData_q <= stack_top_entry[15:8];
        end else if (bus.addr == pcrs_pkg::RegTosUp) begin
          rdData_q <= {pcrs_pkg::UpperPad, stack_top_entry[20:16]};
        end else if (bus.addr == pcrs_pkg::RegStkPtr) begin
          rdData_q <= {stackFull, stackUnder, 1'b0, sp_q};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // fault reset request and run state

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q    <= pcrs_pkg::StIdle;
      resetReq_q <= 1'b0;
    end else if (clkEn) begin
      resetReq_q <= 1'b0;
      case (state_q)
        pcrs_pkg::StIdle: begin
          state_q <= pcrs_pkg::StRun;
        end
        pcrs_pkg::StRun: begin
          if (faultEv) begin
            state_q    <= pcrs_pkg::StFault;
            resetReq_q <= 1'b1;
          end
        end
        pcrs_pkg::StFault: begin
          state_q <= pcrs_pkg::StRun;
        end
        default: begin
          state_q <= pcrs_pkg::StIdle;
        end
      endcase
    end
  end

  assign rdData         = rdData_q;
  assign pcOut          = pc_q;
  assign deviceResetReq = resetReq_q;

endmodule

// ==== verif/pcrs_core_checker.sv ====
// pcrs_core_checker: port assertions for the pc and return stack core.
// assumes: bound into pcrs_core; one clock domain.
`timescale 1ns/1ns
module pcrs_core_checker #(
  parameter int Depth = pcrs_pkg::Depth
) (
  input wire logic                ref_clk,
  input wire logic                resetn,
  input wire logic                clkEn,
  input wire logic                porClear,
  input wire logic                faultResetEn,
  input wire pcrs_pkg::pcrs_ctl_t ctl,
  input wire pcrs_pkg::pcrs_bus_t bus,
  input wire logic [7:0]          rdData,
  input wire logic [20:0]         pcOut,
  input wire logic                stackFull,
  input wire logic                stackUnder,
  input wire logic                deviceResetReq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic ptrWr;
  logic anyOp;
  assign ptrWr = clkEn && bus.wr && bus.addr == pcrs_pkg::RegStkPtr;
  assign anyOp = ctl.push || ctl.pushInsn || ctl.pop || ctl.popInsn;
  ////////////////////////////////////////////////////////////////////////////
  a_pc_even: assert property (pcOut[0] == 1'b0)
    else $error("pc odd");
  a_pc_step: assert property (clkEn && ctl.advance |=>
    pcOut == $past(pcOut) + pcrs_pkg::PcStep) else $error("bad step");
  a_branch_load: assert property (clkEn && ctl.branch |=>
    pcOut == $past(ctl.target)) else $error("bad branch");
  a_call_load: assert property (clkEn && ctl.push |=>
    pcOut == $past(ctl.target)) else $error("bad call");
  a_insn_keep: assert property (clkEn && !faultResetEn &&
    (ctl.pushInsn || ctl.popInsn) |=> $stable(pcOut))
    else $error("pc moved");
  a_rd_idle: assert property (clkEn && !bus.rd |=> rdData == 8'h00)
    else $error("stray read data");
  a_ptr_layout: assert property (clkEn && bus.rd && !anyOp &&
    bus.addr == pcrs_pkg::RegStkPtr |=> rdData[5] == 1'b0 &&
    rdData[7:6] == {$past(stackFull), $past(stackUnder)})
    else $error("bad pointer layout");
  a_full_sticky: assert property (stackFull && !porClear && !ptrWr
    |=> stackFull) else $error("full lost");
  a_unf_sticky: assert property (stackUnder && !porClear && !ptrWr
    |=> stackUnder) else $error("underflow lost");
  a_por_clear: assert property (clkEn && porClear && !anyOp |=>
    !stackFull && !stackUnder) else $error("flags kept");
  a_full_cause: assert property ($rose(stackFull) |->
    $past(ctl.push || ctl.pushInsn)) else $error("full without push");
  a_fault_pulse: assert property (deviceResetReq |-> stackFull
    ##1 !deviceResetReq) else $error("bad reset request");
endmodule

bind pcrs_core pcrs_core_checker #(.Depth(Depth)) chk_u (
  .ref_clk(ref_clk), .resetn(resetn), .clkEn(clkEn),
  .porClear(porClear), .faultResetEn(faultResetEn), .ctl(ctl),
  .bus(bus), .rdData(rdData), .pcOut(pcOut), .stackFull(stackFull),
  .stackUnder(stackUnder), .deviceResetReq(deviceResetReq));

// ==== verif/pcrs_exec_model.sv ====
// pcrs_exec_model: execution and interrupt logic issuing one op at a time.
// assumes: ops are one-hot {advance,branch,push,pushInsn,pop,popInsn}.
`timescale 1ns/1ns
module pcrs_exec_model (
  input  wire logic          ref_clk,
  output pcrs_pkg::pcrs_ctl_t ctl
);
  initial ctl = '0;
  // serial issue only
  // the bench never overlaps an op with a stack register access
  // interrupt acknowledge
  // an interrupt is a push whose pc already names the next instruction
  task automatic issue(input logic [5:0] op, input logic [20:0] tgt);
    @(posedge ref_clk);
    ctl <= {op, tgt};
    @(posedge ref_clk);
    ctl <= {6'h00, ~tgt};
    #1;
  endtask
endmodule

// ==== verif/pcrs_core_test.sv ====
// pcrs_core_test: directed checks of the pc and return stack core.
// assumes: pcrs_exec_model drives ctl; bench drives the register port.
`timescale 1ns/1ns
module pcrs_core_test;
  localparam logic [5:0] OpAdv = 6'h20;
  localparam logic [5:0] OpBr  = 6'h10;
  localparam logic [5:0] OpCal = 6'h08;
  localparam logic [5:0] OpPsh = 6'h04;
  localparam logic [5:0] OpRet = 6'h02;
  localparam logic [5:0] OpPop = 6'h01;
  logic                ref_clk;
  logic                resetn;
  logic                clkEn;
  logic                porClear;
  logic                faultResetEn;
  pcrs_pkg::pcrs_ctl_t ctl;
  pcrs_pkg::pcrs_bus_t bus;
  logic [7:0]          rdData;
  logic [20:0]         pcOut;
  logic                stackFull;
  logic                stackUnder;
  logic                deviceResetReq;
  logic                sawReq;
  int                  n_errors;
  int                  tests_run;

  pcrs_core dut_u (.ref_clk(ref_clk), .resetn(resetn), .clkEn(clkEn),
    .porClear(porClear), .faultResetEn(faultResetEn), .ctl(ctl),
    .bus(bus), .rdData(rdData), .pcOut(pcOut), .stackFull(stackFull),
    .stackUnder(stackUnder), .deviceResetReq(deviceResetReq));
  pcrs_exec_model cpu_u (.ref_clk(ref_clk), .ctl(ctl));

  initial ref_clk = 1'b0;
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (deviceResetReq === 1'b1) sawReq <= 1'b1;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [20:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
    // let the edge's updates settle before anyone looks at outputs
    #1;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1 d = rdData;
  endtask
  task automatic rdChk(input logic [2:0] a, input logic [7:0] e,
                       input string nm);
    logic [7:0] d;
    rd(a, d);
    chk(nm, {13'h0, d}, {13'h0, e});
  endtask
  task automatic ptrChk(input logic [7:0] e);
    rdChk(pcrs_pkg::RegStkPtr, e, "pointer");
  endtask
  task automatic tosChk(input logic [20:0] e, input string nm);
    logic [7:0] u, h, l;
    rd(pcrs_pkg::RegTosUp, u);
    rd(pcrs_pkg::RegTosHi, h);
    rd(pcrs_pkg::RegTosLow, l);
    chk(nm, {u[4:0], h, l}, e);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_errors++;
    finish_test();
  end

  initial begin
    resetn = 1'b0;
    clkEn = 1'b1;
    porClear = 1'b0;
    faultResetEn = 1'b0;
    bus = '0;
    sawReq = 1'b0;
    n_errors = 0;
    tests_run = 0;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    ptrChk(8'h00);
    rdChk(3'h7, 8'h00, "unmapped");
    $display("test reset done");
    wr(pcrs_pkg::RegLatHi, 8'h12);
    wr(pcrs_pkg::RegLatUp, 8'h03);
    cpu_u.issue(OpBr, 21'h0abcd0);
    chk("branch", pcOut, 21'h0abcd0);
    cpu_u.issue(OpAdv, 21'h0);
    chk("advance", pcOut, 21'h0abcd2);
    wr(pcrs_pkg::RegPcLow, 8'h44);
    chk("low write", pcOut, 21'h031244);
    cpu_u.issue(OpBr, 21'h1f5678);
    rdChk(pcrs_pkg::RegPcLow, 8'h78, "low read");
    rdChk(pcrs_pkg::RegLatHi, 8'h56, "high latch");
    rdChk(pcrs_pkg::RegLatUp, 8'h1f, "upper latch");
    @(posedge ref_clk) clkEn <= 1'b0;
    cpu_u.issue(OpAdv, 21'h0);
    chk("frozen", pcOut, 21'h1f5678);
    @(posedge ref_clk) clkEn <= 1'b1;
    $display("test pc done");
    cpu_u.issue(OpBr, 21'h000100);
    cpu_u.issue(OpCal, 21'h002000);
    chk("call pc", pcOut, 21'h002000);
    ptrChk(8'h01);
    tosChk(21'h000100, "call entry");
    cpu_u.issue(OpPsh, 21'h0);
    ptrChk(8'h02);
    tosChk(21'h002000, "push entry");
    cpu_u.issue(OpPop, 21'h0);
    tosChk(21'h000100, "pop entry");
    chk("pop pc", pcOut, 21'h002000);
    cpu_u.issue(OpRet, 21'h0);
    chk("return pc", pcOut, 21'h000100);
    ptrChk(8'h00);
    cpu_u.issue(OpRet, 21'h0);
    chk("underflow pc", pcOut, 21'h0);
    ptrChk(8'h40);
    rdChk(pcrs_pkg::RegLatHi, 8'h56, "latch kept");
    wr(pcrs_pkg::RegStkPtr, 8'h00);
    ptrChk(8'h00);
    $display("test stack done");
    wr(pcrs_pkg::RegStkPtr, 8'h03);
    wr(pcrs_pkg::RegTosUp, 8'h1a);
    wr(pcrs_pkg::RegTosHi, 8'hbc);
    wr(pcrs_pkg::RegTosLow, 8'hde);
    tosChk(21'h1abcde, "entry write");
    cpu_u.issue(OpRet, 21'h0);
    chk("entry return", pcOut, 21'h1abcde);
    ptrChk(8'h02);
    $display("test top access done");
    wr(pcrs_pkg::RegStkPtr, 8'h00);
    cpu_u.issue(OpBr, 21'h000040);
    for (int i = 1; i <= 31; i++) begin
      cpu_u.issue(OpPsh, 21'h0);
      chk("full", {20'h0, stackFull}, {20'h0, i == 31});
    end
    ptrChk(8'h9f);
    cpu_u.issue(OpBr, 21'h000080);
    cpu_u.issue(OpPsh, 21'h0);
    ptrChk(8'h9f);
    tosChk(21'h000040, "kept entry");
    wr(pcrs_pkg::RegStkPtr, 8'h00);
    chk("full cleared", {20'h0, stackFull}, 21'h0);
    cpu_u.issue(OpRet, 21'h0);
    @(posedge ref_clk) porClear <= 1'b1;
    @(posedge ref_clk) porClear <= 1'b0;
    #1 chk("por clear", {20'h0, stackUnder}, 21'h0);
    $display("test overflow done");
    @(posedge ref_clk) faultResetEn <= 1'b1;
    cpu_u.issue(OpBr, 21'h000200);
    for (int i = 1; i <= 31; i++) cpu_u.issue(OpPsh, 21'h0);
    repeat (2) @(posedge ref_clk);
    chk("reset request", {20'h0, sawReq}, 21'h1);
    ptrChk(8'h80);
    wr(pcrs_pkg::RegStkPtr, 8'h1f);
    tosChk(21'h000202, "fault entry");
    $display("test fault done");
    finish_test();
  end
endmodule
